// file: rtl/sac_defines.vh
// Register map, field positions, reset values and timing counts of the access-control block.
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH

// Byte offsets of the Avalon registers.
`define SAC_OFF_CTRL 8'h00
`define SAC_OFF_LIMIT 8'h04
`define SAC_OFF_PWEV 8'h08
`define SAC_OFF_AUEV 8'h0C
`define SAC_OFF_ENEV 8'h10
`define SAC_OFF_MACEV 8'h14
`define SAC_OFF_REQ 8'h18
`define SAC_OFF_DATA 8'h1C
`define SAC_OFF_RES 8'h20
`define SAC_OFF_STAT 8'h24
`define SAC_ZONE_PAGE 3'h2

// Reset values.
`define SAC_CTRL_RST 2'h0
`define SAC_LIMIT_RST 8'h33
`define SAC_ZONE_RST 11'h000

// Zone configuration field positions.
`define SAC_Z_LOCK 0
`define SAC_Z_ENC 1
`define SAC_Z_MF 2
`define SAC_Z_PO 3
`define SAC_Z_KEY 4
`define SAC_Z_PWS 6
`define SAC_Z_PWREQ 9
`define SAC_Z_AUREQ 10

// Communication security modes.
`define SAC_MODE_STD 2'h0
`define SAC_MODE_AUTH 2'h1
`define SAC_MODE_ENC 2'h2

// Password sets with special meaning and the password area of configuration memory.
`define SAC_SEC_SET 3'h7
`define SAC_SUP_SET 3'h0
`define SAC_PW_LO 8'hB0
`define SAC_PW_HI 8'hEF

// Write length limits.
`define SAC_AT_MAX_LEN 5'h08
`define SAC_LOCK_LEN 5'h01

// Nonvolatile memory commands.
`define SAC_NVM_NONE 2'h0
`define SAC_NVM_BUF 2'h1
`define SAC_NVM_COPY 2'h2
`define SAC_NVM_REST 2'h3

// Link power-up counts, in link clock cycles; the boot wait counts system clock cycles.
`define SAC_ATR_CYC 9'h190
`define SAC_SYNC_PULSES 3'h5
`define SAC_ATR_BITS 7'h40
`define SAC_BOOT_WAIT 2'h3

`endif

// file: rtl/sac_top.v
// Access-control core of a secure serial memory: security state, write checks and link start-up.
`timescale 1ns/1ps
`default_nettype none
`include "sac_defines.vh"

module sac_top #(
    parameter [63:0] ATR_CODE = 64'h0123456789ABCDEF // Arbitrary answer-to-reset value.
) (
    input wire ref_clk,
    input wire rst_n,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire link_clk,
    input wire link_rst,
    input wire link_io_in,
    output reg link_io_out,
    output reg link_io_oe,
    output wire link_ack_ok,
    output reg [1:0] nvm_cmd,
    input wire nvm_done,
    input wire nvm_pending
);

    localparam P_BOOT = 3'h0;
    localparam P_COUNT = 3'h1;
    localparam P_ATR = 3'h2;
    localparam P_PRE = 3'h3;
    localparam P_RUN = 3'h4;

    localparam A_BOOT = 3'h0;
    localparam A_IDLE = 3'h1;
    localparam A_BUF = 3'h2;
    localparam A_COPY = 3'h3;
    localparam A_REST = 3'h4;

    reg ack_q;
    reg [1:0] ctrl_q;
    reg [7:0] lim_q;
    reg [10:0] zone_q [0:7];
    reg [16:0] req_q;
    reg [23:0] data_q;
    reg [15:0] res_q;
    reg pw_valid_q;
    reg [2:0] pw_set_q;
    reg pw_write_q;
    reg [3:0] pw_fail_q;
    reg pw_res_q;
    reg auth_valid_q;
    reg [1:0] auth_key_q;
    reg [3:0] auth_fail_q;
    reg auth_res_q;
    reg [1:0] mode_q;
    reg abandon_q;
    reg [2:0] p_st_q;
    reg [1:0] boot_cnt_q;
    reg [8:0] cyc_q;
    reg [2:0] pulse_q;
    reg [6:0] bit_q;
    reg [63:0] atr_q;
    reg async_q;
    reg fixed_q;
    reg [1:0] lclk_s;
    reg [1:0] lrst_s;
    reg [1:0] lio_s;
    reg lclk_d;
    reg [2:0] a_st_q;
    integer i;

    // One wait cycle per access: read data is loaded while waitrequest is high.
    wire bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_q;
    wire wr_en = avs_write & ack_q;
    wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] wdm = avs_writedata & be_mask;
    wire [1:0] ctrl_d = (ctrl_q & ~be_mask[1:0]) | wdm[1:0];
    wire [7:0] lim_d = (lim_q & ~be_mask[7:0]) | wdm[7:0];
    wire [16:0] req_d = (req_q & ~be_mask[16:0]) | wdm[16:0];
    wire [23:0] data_d = (data_q & ~be_mask[23:0]) | wdm[23:0];
    wire zone_hit = avs_address[7:5] == `SAC_ZONE_PAGE;

    // Event strobes, each one cycle at the edge where the write is taken.
    wire ev_pw = wr_en & (avs_address == `SAC_OFF_PWEV);
    wire ev_au = wr_en & (avs_address == `SAC_OFF_AUEV);
    wire ev_en = wr_en & (avs_address == `SAC_OFF_ENEV);
    wire ev_mac = wr_en & (avs_address == `SAC_OFF_MACEV);
    wire ev_data = wr_en & (avs_address == `SAC_OFF_DATA);

    // Trial limits: a counter above the limit blocks even a correct attempt.
    wire pw_locked = pw_fail_q > lim_q[3:0];
    wire auth_locked = auth_fail_q > lim_q[7:4];

    // Secure code and supervisor password privileges.
    wire pw_w_ok = pw_valid_q & pw_write_q;
    wire cfg_ok = pw_w_ok & (pw_set_q == `SAC_SEC_SET);
    wire sup_ok = ctrl_q[1] & pw_w_ok & (pw_set_q == `SAC_SUP_SET);

    // Fields of the request under evaluation.
    wire [10:0] zc = zone_q[req_q[9:7]];
    wire [2:0] bi = req_q[2:0];
    wire is_cfg = req_q[10];
    wire is_rd = req_q[16];
    wire [4:0] len = req_q[15:11];
    wire [7:0] new_b = data_d[7:0];
    wire [7:0] old_b = data_d[15:8];
    wire [7:0] lock_b = data_d[23:16];
    wire lock_on = ~is_cfg & zc[`SAC_Z_LOCK];
    wire at_on = ctrl_q[0];
    wire at_busy = a_st_q != A_IDLE;

    // Configuration memory: password area opens to the supervisor too.
    wire in_pw = (req_q[7:0] >= `SAC_PW_LO) & (req_q[7:0] <= `SAC_PW_HI);
    wire cfg_grant = in_pw ? (cfg_ok | sup_ok) : cfg_ok;

    // User zone checks; each term refuses the request on its own.
    wire enc_bad = zc[`SAC_Z_ENC] & (mode_q != `SAC_MODE_ENC);
    wire key_ok = auth_key_q == zc[`SAC_Z_KEY +: 2];
    wire auth_bad = zc[`SAC_Z_AUREQ] & ~(auth_valid_q & key_ok);
    wire set_ok = pw_valid_q & (pw_set_q == zc[`SAC_Z_PWS +: 3]);
    wire pw_bad = zc[`SAC_Z_PWREQ] & ~(set_ok & (is_rd | pw_write_q));
    // Bit n of the lock byte guards byte n; byte 0 is the lock byte itself.
    wire lock_bad = lock_on & ~is_rd & ~lock_b[bi];
    wire mf_bad = zc[`SAC_Z_MF] & ~is_rd;
    wire user_ok = ~(enc_bad | auth_bad | pw_bad | lock_bad | mf_bad);
    wire grant = ~at_busy & (is_cfg ? cfg_grant : user_ok);

    // Accepted length: writes to locked pages take one byte, anti-tearing writes at most eight; reads keep their length.
    reg [4:0] acc_len;
    always @* begin
        if (is_rd) begin
            acc_len = len;
        end else if (lock_on) begin
            acc_len = `SAC_LOCK_LEN;
        end else if (at_on && (len > `SAC_AT_MAX_LEN)) begin
            acc_len = `SAC_AT_MAX_LEN;
        end else begin
            acc_len = len;
        end
    end

    // Program-only bytes and the lock byte can only clear bits.
    wire clr_only = ~is_cfg & (zc[`SAC_Z_PO] | (lock_on & (bi == 3'h0)));
    wire [7:0] out_b = clr_only ? (new_b & old_b) : new_b;
    wire tx_enc = ~is_cfg & (mode_q == `SAC_MODE_ENC);
    wire at_start = ev_data & grant & ~is_rd & at_on;

    // Link sampling; only the second stage of each pair is looked at.
    wire lclk = lclk_s[1];
    wire lrst = lrst_s[1];
    wire lclk_rise = lclk & ~lclk_d;
    wire lclk_fall = ~lclk & lclk_d;
    wire link_ready = p_st_q == P_RUN;
    // In card mode a low reset pin wipes memorized passwords and authentication.
    wire sec_clr = async_q & link_ready & ~lrst;

    wire [31:0] status = {9'h000, lio_s[1], auth_res_q, pw_res_q, abandon_q,
                          (mode_q != `SAC_MODE_STD), sup_ok, cfg_ok, at_busy,
                          link_ready, fixed_q, async_q, auth_locked, pw_locked,
                          auth_key_q, auth_valid_q, pw_write_q, pw_set_q,
                          pw_valid_q, mode_q};

    // Bus handshake.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req & ~ack_q;
        end
    end

    // Read data is captured in the wait cycle; unmapped offsets read zero.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read & ~ack_q) begin
            if (zone_hit) begin
                avs_readdata <= {21'h000000, zone_q[avs_address[4:2]]};
            end else begin
                case (avs_address)
                    `SAC_OFF_CTRL: avs_readdata <= {30'h00000000, ctrl_q};
                    `SAC_OFF_LIMIT: avs_readdata <= {24'h000000, lim_q};
                    `SAC_OFF_REQ: avs_readdata <= {15'h0000, req_q};
                    `SAC_OFF_DATA: avs_readdata <= {8'h00, data_q};
                    `SAC_OFF_RES: avs_readdata <= {16'h0000, res_q};
                    `SAC_OFF_STAT: avs_readdata <= status;
                    default: avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Configuration registers and the request under evaluation.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `SAC_CTRL_RST;
            lim_q <= `SAC_LIMIT_RST;
            req_q <= 17'h00000;
            data_q <= 24'h000000;
            res_q <= 16'h0000;
            for (i = 0; i < 8; i = i + 1) begin
                zone_q[i] <= `SAC_ZONE_RST;
            end
        end else if (wr_en) begin
            if (zone_hit) begin
                zone_q[avs_address[4:2]] <= (zone_q[avs_address[4:2]] & ~be_mask[10:0])
                                            | wdm[10:0];
            end
            if (avs_address == `SAC_OFF_CTRL) begin
                ctrl_q <= ctrl_d;
            end
            if (avs_address == `SAC_OFF_LIMIT) begin
                lim_q <= lim_d;
            end
            if (avs_address == `SAC_OFF_REQ) begin
                req_q <= req_d;
            end
            // Writing the data word runs the checks on the stored request.
            if (ev_data) begin
                data_q <= data_d;
                res_q <= {at_busy, tx_enc, out_b, acc_len, grant};
            end
        end
    end

    // Password and authentication state; a new attempt replaces the old result.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pw_valid_q <= 1'b0;
            pw_set_q <= 3'h0;
            pw_write_q <= 1'b0;
            pw_fail_q <= 4'h0;
            pw_res_q <= 1'b0;
            auth_valid_q <= 1'b0;
            auth_key_q <= 2'h0;
            auth_fail_q <= 4'h0;
            auth_res_q <= 1'b0;
            mode_q <= `SAC_MODE_STD;
            abandon_q <= 1'b0;
        end else if (sec_clr) begin
            pw_valid_q <= 1'b0;
            auth_valid_q <= 1'b0;
            mode_q <= `SAC_MODE_STD;
        end else begin
            if (ev_pw) begin
                pw_res_q <= wdm[3] & ~pw_locked;
                if (!pw_locked) begin
                    pw_valid_q <= wdm[3];
                    pw_set_q <= wdm[2:0];
                    pw_write_q <= wdm[4];
                    if (!wdm[3] && (pw_fail_q != 4'hF)) begin
                        pw_fail_q <= pw_fail_q + 4'h1;
                    end
                end
            end
            if (ev_au) begin
                auth_res_q <= wdm[2] & ~auth_locked;
                if (!auth_locked) begin
                    // A failed retry drops the privilege held so far.
                    auth_valid_q <= wdm[2];
                    auth_key_q <= wdm[1:0];
                    mode_q <= wdm[2] ? `SAC_MODE_AUTH : `SAC_MODE_STD;
                    abandon_q <= 1'b0;
                    if (!wdm[2] && (auth_fail_q != 4'hF)) begin
                        auth_fail_q <= auth_fail_q + 4'h1;
                    end
                end
            end
            if (ev_en && wdm[0] && auth_valid_q) begin
                mode_q <= `SAC_MODE_ENC;
            end
            // A bad MAC kills the command and the privilege until re-authentication.
            if (ev_mac && wdm[0] && (mode_q != `SAC_MODE_STD)) begin
                auth_valid_q <= 1'b0;
                mode_q <= `SAC_MODE_STD;
                abandon_q <= 1'b1;
            end
        end
    end

    // Anti-tearing sequencer; the pending flag is caught just after reset release.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_st_q <= A_BOOT;
            nvm_cmd <= `SAC_NVM_NONE;
        end else begin
            case (a_st_q)
                A_BOOT: begin
                    if (nvm_pending) begin
                        a_st_q <= A_REST;
                        nvm_cmd <= `SAC_NVM_REST;
                    end else begin
                        a_st_q <= A_IDLE;
                    end
                end
                A_IDLE: begin
                    if (at_start) begin
                        a_st_q <= A_BUF;
                        nvm_cmd <= `SAC_NVM_BUF;
                    end
                end
                A_BUF: begin
                    if (nvm_done) begin
                        a_st_q <= A_COPY;
                        nvm_cmd <= `SAC_NVM_COPY;
                    end
                end
                A_COPY, A_REST: begin
                    if (nvm_done) begin
                        a_st_q <= A_IDLE;
                        nvm_cmd <= `SAC_NVM_NONE;
                    end
                end
                default: begin
                    a_st_q <= A_IDLE;
                    nvm_cmd <= `SAC_NVM_NONE;
                end
            endcase
        end
    end

    // The host polls this until a power-up recovery is over.
    assign link_ack_ok = ~at_busy;

    // Two-flop synchronisers for the link pins and an edge-detect stage.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lclk_s <= 2'h0;
            lrst_s <= 2'h0;
            lio_s <= 2'h0;
            lclk_d <= 1'b0;
        end else begin
            lclk_s <= {lclk_s[0], link_clk};
            lrst_s <= {lrst_s[0], link_rst};
            lio_s <= {lio_s[0], link_io_in};
            lclk_d <= lclk;
        end
    end

    // Protocol selection runs once per power cycle and is never revisited.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            p_st_q <= P_BOOT;
            boot_cnt_q <= 2'h0;
            cyc_q <= 9'h000;
            pulse_q <= 3'h0;
            bit_q <= 7'h00;
            atr_q <= 64'h0000000000000000;
            async_q <= 1'b0;
            fixed_q <= 1'b0;
            link_io_out <= 1'b1;
            link_io_oe <= 1'b0;
        end else begin
            case (p_st_q)
                P_BOOT: begin
                    // Wait until the synchronisers hold real pin levels.
                    if (boot_cnt_q != `SAC_BOOT_WAIT) begin
                        boot_cnt_q <= boot_cnt_q + 2'h1;
                    end else if (lrst) begin
                        p_st_q <= P_PRE;
                        fixed_q <= 1'b1;
                    end else begin
                        p_st_q <= P_COUNT;
                    end
                end
                P_COUNT: begin
                    if (lrst) begin
                        fixed_q <= 1'b1;
                        if (cyc_q >= `SAC_ATR_CYC) begin
                            p_st_q <= P_ATR;
                            async_q <= 1'b1;
                            atr_q <= ATR_CODE;
                        end else begin
                            p_st_q <= P_PRE;
                        end
                    end else if (lclk_rise && (cyc_q != `SAC_ATR_CYC)) begin
                        cyc_q <= cyc_q + 9'h001;
                    end
                end
                P_ATR: begin
                    // One answer bit per falling link clock edge, low bit first.
                    if (lclk_fall) begin
                        if (bit_q == `SAC_ATR_BITS) begin
                            link_io_oe <= 1'b0;
                            link_io_out <= 1'b1;
                            p_st_q <= P_RUN;
                        end else begin
                            link_io_oe <= 1'b1;
                            link_io_out <= atr_q[0];
                            atr_q <= {1'b0, atr_q[63:1]};
                            bit_q <= bit_q + 7'h01;
                        end
                    end
                end
                P_PRE: begin
                    // Commands are only expected after the wake-up pulses.
                    if (lclk_rise) begin
                        if (pulse_q == `SAC_SYNC_PULSES - 3'h1) begin
                            p_st_q <= P_RUN;
                        end else begin
                            pulse_q <= pulse_q + 3'h1;
                        end
                    end
                end
                P_RUN: begin
                    p_st_q <= P_RUN;
                end
                default: begin
                    p_st_q <= P_RUN;
                end
            endcase
        end
    end

endmodule // sac_top

`default_nettype wire

// file: bench/sac_checker.sv
// Port-level assertions for the access-control core.
`timescale 1ns/1ps
`default_nettype none
`include "sac_defines.vh"
module sac_checker (
    input wire ref_clk,
    input wire rst_n,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire link_ack_ok,
    input wire [1:0] nvm_cmd,
    input wire nvm_done,
    input wire nvm_pending
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic boot_q;
    // Low only at the first edge after reset, when the pending copy is sampled.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) boot_q <= 1'b0;
        else boot_q <= 1'b1;
    end
    sequence s_buf_done;
        nvm_cmd == `SAC_NVM_BUF && nvm_done;
    endsequence
    sequence s_copy_done;
        nvm_cmd == `SAC_NVM_COPY && nvm_done;
    endsequence
    wait_first_a: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
        |-> avs_waitrequest) else $error("request answered without a wait cycle");
    wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("wait lasted more than one cycle");
    buf_copy_a: assert property (s_buf_done |=> nvm_cmd == `SAC_NVM_COPY)
        else $error("buffer write not followed by copy");
    buf_hold_a: assert property (nvm_cmd == `SAC_NVM_BUF && !nvm_done |=> $stable(nvm_cmd))
        else $error("buffer write left before done");
    copy_end_a: assert property (s_copy_done |=> nvm_cmd == `SAC_NVM_NONE)
        else $error("copy did not end on done");
    // The sampled reset keeps the release edge itself, where the core still sits in reset, out.
    restore_a: assert property (rst_n && !boot_q && nvm_pending
        |=> nvm_cmd == `SAC_NVM_REST && !link_ack_ok)
        else $error("pending copy not restored at power-up");
    boot_idle_a: assert property (rst_n && !boot_q && !nvm_pending |=> link_ack_ok)
        else $error("idle power-up did not acknowledge");
    busy_ack_a: assert property (nvm_cmd != `SAC_NVM_NONE |-> !link_ack_ok)
        else $error("acknowledge given while memory busy");
endmodule // sac_checker
bind sac_top sac_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .link_ack_ok(link_ack_ok),
    .nvm_cmd(nvm_cmd), .nvm_done(nvm_done), .nvm_pending(nvm_pending));
`default_nettype wire

// file: bench/sac_reader.sv
// Card reader and memory array standing on the far side of the core.
`timescale 1ns/1ps
`default_nettype none
module sac_reader (
    input wire ref_clk,
    input wire [1:0] nvm_cmd,
    input wire link_io_out,
    input wire link_io_oe,
    output logic nvm_done,
    output logic link_clk,
    output logic link_rst,
    output wire link_io_in
);
    int wait_q = 0;
    int slow = 2;
    logic [63:0] atr_q = 64'h0;
    logic [6:0] atr_cnt = 7'h00;
    initial begin
        nvm_done = 1'b0;
        link_clk = 1'b0;
        link_rst = 1'b0;
    end
    // The line has a pull-up, so a released line reads high.
    assign link_io_in = link_io_oe ? link_io_out : 1'b1;
    // The array answers each step after a random delay, so fast and slow both occur.
    always @(posedge ref_clk) begin
        nvm_done <= 1'b0;
        if (nvm_cmd == 2'h0 || nvm_done) wait_q <= 0;
        else if (wait_q >= slow) begin
            nvm_done <= 1'b1;
            slow <= $urandom_range(0, 4);
        end else wait_q <= wait_q + 1;
    end
    // The link clock runs only inside frames and rests low between them.
    // Each half period is four system clocks, so the pins move right after a rising edge.
    task automatic frame(input int n);
        repeat (n) begin
            repeat (4) @(posedge ref_clk);
            link_clk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            link_clk <= 1'b0;
        end
    endtask
    task automatic cold_start();
        link_rst <= 1'b0;
        frame(400);
        link_rst <= 1'b1;
        frame(70);
    endtask
    task automatic two_wire();
        link_rst <= 1'b1;
        frame(5);
    endtask
    // Bits change on the fall and are taken on the following rise.
    always @(posedge link_clk) begin
        if (link_io_oe) begin
            atr_q <= {link_io_out, atr_q[63:1]};
            atr_cnt <= atr_cnt + 7'h01;
        end
    end
endmodule // sac_reader
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the access-control core.
`timescale 1ns/1ps
`default_nettype none
`include "sac_defines.vh"
module tb;
    localparam logic [63:0] ATR = 64'h5A3C96E10F1E2D4B; // Arbitrary answer value.
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic nvm_pending = 1'b0;
    wire [31:0] avs_readdata;
    wire [1:0] nvm_cmd;
    wire avs_waitrequest, link_clk, link_rst, link_io_in, link_io_out, link_io_oe;
    wire link_ack_ok, nvm_done;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int k;
    logic [31:0] q;
    logic [7:0] nw, od, lk;
    sac_top #(.ATR_CODE(ATR)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .link_clk(link_clk), .link_rst(link_rst), .link_io_in(link_io_in),
        .link_io_out(link_io_out), .link_io_oe(link_io_oe), .link_ack_ok(link_ack_ok),
        .nvm_cmd(nvm_cmd), .nvm_done(nvm_done), .nvm_pending(nvm_pending));
    sac_reader u_rd (.ref_clk(ref_clk), .nvm_cmd(nvm_cmd), .link_io_out(link_io_out),
        .link_io_oe(link_io_oe), .nvm_done(nvm_done), .link_clk(link_clk),
        .link_rst(link_rst), .link_io_in(link_io_in));
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // A hang ends the run; the sequence needs under a third of this.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One access; the request holds until waitrequest is low at a rising edge.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic st();
        bus(1'b0, `SAC_OFF_STAT, 32'h0);
    endtask
    function automatic logic [31:0] rq(input logic [4:0] len, input logic cfg, input logic [9:0] loc);
        return {16'h0000, len, cfg, loc};
    endfunction
    task automatic acc(input logic [31:0] r, input logic [7:0] n, input logic [7:0] l);
        bus(1'b1, `SAC_OFF_REQ, r);
        bus(1'b1, `SAC_OFF_DATA, {8'h00, l, od, n});
        bus(1'b0, `SAC_OFF_RES, 32'h0);
    endtask
    task automatic power();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
    endtask
    task automatic idle_wait();
        k = 0;
        while (link_ack_ok !== 1'b1 && k < 200) begin
            @(posedge ref_clk);
            k++;
        end
        chk("ack", link_ack_ok, 1'b1);
    endtask
    // Start-up and link first, then each protection feature in turn.
    initial begin
        q = $urandom(76);
        power();
        st();
        chk("mode", q[1:0], `SAC_MODE_STD);
        bus(1'b0, 8'h80, 32'h0);
        chk("unmapped", q, 32'h0);
        u_rd.cold_start();
        chk("atr", u_rd.atr_q, ATR);
        chk("atr bits", u_rd.atr_cnt, 7'h40);
        u_rd.two_wire();
        st();
        chk("async kept", q[13:12], 2'h3);
        nvm_pending <= 1'b1;
        power();
        nvm_pending <= 1'b0;
        idle_wait();
        u_rd.two_wire();
        st();
        chk("two wire", q[14:12], 3'h6);
        // Page-locked zone 0 with random pages, bytes and lock bytes.
        bus(1'b1, 8'h40, 32'h1);
        repeat (24) begin
            k = $urandom_range(0, 7);
            nw = $urandom;
            lk = $urandom;
            od = (k == 0) ? lk : 8'($urandom);
            acc(rq(5'($urandom_range(1, 8)), 1'b0, {3'h0, 4'($urandom), k[2:0]}), nw, lk);
            chk("lock grant", q[0], lk[k]);
            if (lk[k]) chk("lock store", q[13:1], {(k == 0) ? nw & od : nw, 5'h01});
        end
        // Program-only zone 1, modify-forbidden zone 2, encryption-required zone 3.
        bus(1'b1, 8'h44, 32'h8);
        bus(1'b1, 8'h48, 32'h4);
        bus(1'b1, 8'h4C, 32'h2);
        acc(rq(5'h01, 1'b0, 10'h080), nw, 8'hFF);
        chk("prog only", q[13:0], {nw & od, 5'h01, 1'b1});
        acc(rq(5'h01, 1'b0, 10'h100), nw, 8'hFF);
        chk("mod forbid", q[0], 1'b0);
        acc(rq(5'h01, 1'b0, 10'h180), nw, 8'hFF);
        chk("enc std", q[0], 1'b0);
        lk = $urandom;
        bus(1'b1, `SAC_OFF_AUEV, {29'h0, 1'b1, lk[1:0]});
        st();
        chk("auth ok", {q[18], q[9:7], q[1:0]}, {1'b1, lk[1:0], 3'h5});
        bus(1'b1, `SAC_OFF_ENEV, 32'h1);
        acc(rq(5'h01, 1'b0, 10'h180), nw, 8'hFF);
        chk("enc grant", {q[14], q[0]}, 2'h3);
        bus(1'b1, `SAC_OFF_MACEV, 32'h1);
        bus(1'b1, `SAC_OFF_ENEV, 32'h1);
        st();
        chk("mac revoke", {q[19], q[7], q[1:0]}, 4'h8);
        bus(1'b1, `SAC_OFF_AUEV, 32'h4);
        bus(1'b1, `SAC_OFF_AUEV, 32'h0);
        st();
        chk("auth fail", q[7], 1'b0);
        // Secure code, supervisor, then attempt limits.
        acc(rq(5'h01, 1'b1, 10'h020), nw, 8'hFF);
        chk("cfg closed", q[0], 1'b0);
        bus(1'b1, `SAC_OFF_PWEV, 32'h1F);
        st();
        chk("secure code", {q[16], q[6:2]}, 6'h3F);
        acc(rq(5'h01, 1'b1, 10'h020), nw, 8'hFF);
        chk("cfg open", q[0], 1'b1);
        bus(1'b1, `SAC_OFF_CTRL, 32'h2);
        bus(1'b1, `SAC_OFF_PWEV, 32'h18);
        st();
        chk("supervisor", q[17], 1'b1);
        // Zone 5 wants password set 0; the write password held now must open reads too.
        bus(1'b1, 8'h54, 32'h200);
        acc(rq(5'h01, 1'b0, 10'h280) | 32'h10000, nw, 8'hFF);
        chk("wr pw read", q[0], 1'b1);
        bus(1'b1, `SAC_OFF_LIMIT, 32'h0);
        bus(1'b1, `SAC_OFF_PWEV, 32'h13);
        bus(1'b1, `SAC_OFF_PWEV, 32'h1B);
        bus(1'b1, `SAC_OFF_AUEV, 32'h4);
        st();
        chk("locked", {q[11:10], q[7], q[2]}, 4'hC);
        // Anti-tearing caps the length and runs the buffered sequence.
        bus(1'b1, `SAC_OFF_CTRL, 32'h1);
        acc(rq(5'h09, 1'b0, 10'h200), nw, 8'hFF);
        chk("tear len", q[5:0], 6'h11);
        idle_wait();
        end_of_test();
    end
endmodule // tb
`default_nettype wire
